// >>> design/bcr_regs.v
// Buck converter control register bank with AHB-Lite slave.
// Assumes one bus master, single word transfers, synchronous key input.
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "bcr_defs.vh"
module bcr_regs #(
  parameter [31:0] STEP1_CYC = `BCR_STEP1_CYC,
  parameter [31:0] STEP2_CYC = `BCR_STEP2_CYC,
  parameter [31:0] STEP3_CYC = `BCR_STEP3_CYC
)(
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  // Key and OTP load
  input wire key_unlocked,
  input wire otp_load,
  input wire [4:0] otp_on_code,
  // Hardware scaling pins
  input wire hw_scaling_input_one,
  input wire hw_scaling_input_two,
  // Buck3 start request and ramp status
  input wire buck3_start,
  output reg [1:0] buck3_ramp_step,
  output reg buck3_ramp_busy,
  // Decoded controls
  output reg [9:0] buck3_hyst_limit_ma,
  output reg [11:0] buck3_on_mv,
  output reg [11:0] buck3_sleep_mv,
  output reg [6:0] buck2_on_code_clamped,
  output reg [6:0] buck2_sleep_code_clamped,
  output reg [6:0] buck2_scaling_code_clamped,
  output reg buck2_scaling_active,
  output reg [1:0] buck3_output_cap_range,
  output reg buck3_overvoltage_guard
);
  // Ramp states
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_STEP = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;
  // Buck2 on code lives outside this bank; taken from the buck2 sleep register
  reg [15:0] b2_sleep_r;
  reg [15:0] b2_scale_r;
  reg [15:0] b3_ctl1_r;
  reg [15:0] b3_ctl2_r;
  reg [15:0] b3_on_r;
  reg [15:0] b3_sleep_r;
  // Data phase capture
  reg wr_pend_r;
  reg [15:0] wr_idx_r;
  reg [31:0] rdata_r;
  // Pin synchronisers
  reg [1:0] hw_scaling_input_one_s_r;
  reg [1:0] hw_scaling_input_two_s_r;
  // Ramp machine
  reg [2:0] st_r;
  reg [31:0] cnt_r;
  reg [15:0] rd_val;
  wire [15:0] a_idx;
  wire a_take;
  wire [1:0] ramp_code;
  wire [31:0] step_len;
  wire [15:0] wd;

  assign a_idx = haddr[17:2];
  assign a_take = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_r;
  assign wd = hwdata[15:0];
  assign ramp_code = b3_ctl1_r[`BCR_RAMP_HI:`BCR_RAMP_LO];

  // Read mux; undefined bits are masked off
  always @*
  begin
    case (a_idx)
      `BCR_IDX_B2_SLEEP: rd_val = b2_sleep_r & `BCR_MASK_B2_SLEEP;
      `BCR_IDX_B2_SCALE: rd_val = b2_scale_r & `BCR_MASK_B2_SCALE;
      `BCR_IDX_B3_CTL1: rd_val = b3_ctl1_r & `BCR_MASK_B3_CTL1;
      `BCR_IDX_B3_CTL2: rd_val = b3_ctl2_r & `BCR_MASK_B3_CTL2;
      `BCR_IDX_B3_ON: rd_val = b3_on_r & `BCR_MASK_B3_ON;
      `BCR_IDX_B3_SLEEP: rd_val = b3_sleep_r & `BCR_MASK_B3_SLEEP;
      `BCR_IDX_STATUS: rd_val = {11'h000, key_unlocked, buck3_ramp_busy, st_r[2], buck3_ramp_step};
      default: rd_val = 16'h0000;
    endcase
  end

  // Bus slave: capture address phase, write in data phase, zero wait
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_pend_r <= 1'b0;
      wr_idx_r <= 16'h0000;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_r <= a_take & hwrite;
      if (a_take)
        wr_idx_r <= a_idx;
      if (a_take & ~hwrite)
        rdata_r <= {16'h0000, rd_val};
    end
  end

  // Register storage with masked writes, key lock and OTP load
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      b2_sleep_r <= `BCR_RST_ZERO;
      b2_scale_r <= `BCR_RST_ZERO;
      b3_ctl1_r <= `BCR_RST_B3_CTL1;
      b3_ctl2_r <= `BCR_RST_B3_CTL2;
      b3_on_r <= `BCR_RST_ZERO;
      b3_sleep_r <= `BCR_RST_ZERO;
    end
    else
    begin
      if (wr_pend_r)
      begin
        case (wr_idx_r)
          `BCR_IDX_B2_SLEEP: b2_sleep_r <= wd & `BCR_MASK_B2_SLEEP;
          `BCR_IDX_B2_SCALE: b2_scale_r <= wd & `BCR_MASK_B2_SCALE;
          `BCR_IDX_B3_CTL1:
          begin
            // Limit field keeps old value unless key unlocked
            b3_ctl1_r <= wd & `BCR_MASK_B3_CTL1;
            if (!key_unlocked)
              b3_ctl1_r[`BCR_LIM_HI:`BCR_LIM_LO] <= b3_ctl1_r[`BCR_LIM_HI:`BCR_LIM_LO];
          end
          `BCR_IDX_B3_CTL2: b3_ctl2_r <= wd & `BCR_MASK_B3_CTL2;
          `BCR_IDX_B3_ON: b3_on_r <= wd & `BCR_MASK_B3_ON;
          `BCR_IDX_B3_SLEEP: b3_sleep_r <= wd & `BCR_MASK_B3_SLEEP;
          default: b2_sleep_r <= b2_sleep_r;
        endcase
      end
      // OTP load overrides only bits 6:2 of the on code
      if (otp_load)
        b3_on_r[6:2] <= otp_on_code;
    end
  end

  // Hardware scaling pin synchronisers
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hw_scaling_input_one_s_r <= 2'b00;
      hw_scaling_input_two_s_r <= 2'b00;
    end
    else
    begin
      hw_scaling_input_one_s_r <= {hw_scaling_input_one_s_r[0], hw_scaling_input_one};
      hw_scaling_input_two_s_r <= {hw_scaling_input_two_s_r[0], hw_scaling_input_two};
    end
  end

  // Step length selected by ramp code
  assign step_len = (ramp_code == 2'b01) ? STEP1_CYC :
                    (ramp_code == 2'b10) ? STEP2_CYC : STEP3_CYC;

  // Buck3 ramp: three timed current-limit steps
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= ST_IDLE;
      cnt_r <= 32'h0000_0000;
      buck3_ramp_step <= 2'b00;
      buck3_ramp_busy <= 1'b0;
    end
    else
    begin
      case (st_r)
        ST_IDLE:
        begin
          if (buck3_start)
          begin
            // Code 00 starts at once
            if (ramp_code == 2'b00)
            begin
              st_r <= ST_DONE;
              buck3_ramp_step <= `BCR_RAMP_STEPS;
            end
            else
            begin
              st_r <= ST_STEP;
              buck3_ramp_busy <= 1'b1;
              buck3_ramp_step <= 2'b01;
              cnt_r <= step_len - 32'd1;
            end
          end
        end
        ST_STEP:
        begin
          if (cnt_r == 32'h0000_0000)
          begin
            if (buck3_ramp_step == `BCR_RAMP_STEPS)
            begin
              st_r <= ST_DONE;
              buck3_ramp_busy <= 1'b0;
            end
            else
            begin
              buck3_ramp_step <= buck3_ramp_step + 2'b01;
              cnt_r <= step_len - 32'd1;
            end
          end
          else
            cnt_r <= cnt_r - 32'd1;
        end
        ST_DONE:
        begin
          // Stay started until the request drops
          if (!buck3_start)
          begin
            st_r <= ST_IDLE;
            buck3_ramp_step <= 2'b00;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // Decoded outputs, registered
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      buck3_hyst_limit_ma <= 10'd200;
      buck3_on_mv <= 12'd850;
      buck3_sleep_mv <= 12'd850;
      buck2_on_code_clamped <= `BCR_B2_MIN_CODE;
      buck2_sleep_code_clamped <= `BCR_B2_MIN_CODE;
      buck2_scaling_code_clamped <= `BCR_B2_MIN_CODE;
      buck2_scaling_active <= 1'b0;
      buck3_output_cap_range <= 2'b00;
      buck3_overvoltage_guard <= 1'b0;
    end
    else
    begin
      buck3_hyst_limit_ma <= 10'd100 << b3_ctl1_r[`BCR_LIM_HI:`BCR_LIM_LO];
      buck3_on_mv <= b3_mv(b3_on_r[6:0]);
      buck3_sleep_mv <= b3_mv(b3_sleep_r[6:0]);
      // Buck2 on code shares the sleep register's format slot here
      buck2_on_code_clamped <= b2_clamp(b2_sleep_r[6:0]);
      buck2_sleep_code_clamped <= b2_clamp(b2_sleep_r[6:0]);
      buck2_scaling_code_clamped <= b2_clamp(b2_scale_r[6:0]);
      case (b2_scale_r[`BCR_SRC_HI:`BCR_SRC_LO])
        2'b01: buck2_scaling_active <= 1'b1;
        2'b10: buck2_scaling_active <= hw_scaling_input_one_s_r[1];
        2'b11: buck2_scaling_active <= hw_scaling_input_two_s_r[1];
        default: buck2_scaling_active <= 1'b0;
      endcase
      buck3_output_cap_range <= b3_ctl1_r[1:0];
      buck3_overvoltage_guard <= b3_ctl2_r[7];
    end
  end

  // Buck3 code to millivolts, saturating at the top
  function [11:0] b3_mv;
    input [6:0] code;
    begin
      if (code >= `BCR_B3_CLAMP)
        b3_mv = `BCR_B3_MAX_MV;
      else
        // 25 mV per step as 16 + 8 + 1 times the code
        b3_mv = `BCR_B3_BASE_MV + {1'b0, code, 4'h0} + {2'b00, code, 3'h0} + {5'h00, code};
    end
  endfunction

  // Buck2 code clamp at both ends
  function [6:0] b2_clamp;
    input [6:0] code;
    begin
      if (code < `BCR_B2_MIN_CODE)
        b2_clamp = `BCR_B2_MIN_CODE;
      else if (code > `BCR_B2_MAX_CODE)
        b2_clamp = `BCR_B2_MAX_CODE;
      else
        b2_clamp = code;
    end
  endfunction
endmodule // bcr_regs

// >>> common/bcr_defs.vh
// Constants for the buck converter control register bank.
// Assumes a 25 MHz core clock and a word-per-register AHB-Lite map.
`ifndef BCR_DEFS_VH
`define BCR_DEFS_VH
// Register indices; byte address is index times four
`define BCR_IDX_B2_SLEEP 16'h405E
`define BCR_IDX_B2_SCALE 16'h405F
`define BCR_IDX_B3_CTL1 16'h4060
`define BCR_IDX_B3_CTL2 16'h4061
`define BCR_IDX_B3_ON 16'h4062
`define BCR_IDX_B3_SLEEP 16'h4063
// Own status register index
`define BCR_IDX_STATUS 16'h4070
// Writable masks per register
`define BCR_MASK_B2_SLEEP 16'hE37F
`define BCR_MASK_B2_SCALE 16'h187F
`define BCR_MASK_B3_CTL1 16'h10BF
`define BCR_MASK_B3_CTL2 16'hDF80
`define BCR_MASK_B3_ON 16'hE37F
`define BCR_MASK_B3_SLEEP 16'hE37F
// Reset values
`define BCR_RST_B3_CTL1 16'h0014
`define BCR_RST_B3_CTL2 16'h0300
`define BCR_RST_ZERO 16'h0000
// Field positions
`define BCR_LIM_LO 2
`define BCR_LIM_HI 3
`define BCR_RAMP_LO 4
`define BCR_RAMP_HI 5
`define BCR_SRC_LO 11
`define BCR_SRC_HI 12
// Voltage codes in millivolts
`define BCR_B3_BASE_MV 12'd850
`define BCR_B3_STEP_MV 25
`define BCR_B3_MAX_MV 12'd3400
`define BCR_B3_CLAMP 7'h66
`define BCR_B2_MIN_CODE 7'h08
`define BCR_B2_MAX_CODE 7'h68
// Ramp step times in microseconds, cycles at 25 MHz
`define BCR_CLK_MHZ 25
`define BCR_STEP1_US 512
`define BCR_STEP2_US 4096
`define BCR_STEP3_US 32768
`define BCR_STEP1_CYC (`BCR_STEP1_US * `BCR_CLK_MHZ)
`define BCR_STEP2_CYC (`BCR_STEP2_US * `BCR_CLK_MHZ)
`define BCR_STEP3_CYC (`BCR_STEP3_US * `BCR_CLK_MHZ)
`define BCR_RAMP_STEPS 2'h3
`endif

// >>> test/bcr_regs_sva.sv
// Checker for the buck register bank outputs.
// Assumes it is bound to bcr_regs and sees only its ports.
`timescale 1ns/10ps
module bcr_regs_sva (
  // Clock, reset and bus
  input wire core_clk,
  input wire rst_n,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hrdata,
  // Key, ramp status and decoded controls
  input wire key_unlocked,
  input wire [1:0] buck3_ramp_step,
  input wire buck3_ramp_busy,
  input wire [9:0] buck3_hyst_limit_ma,
  input wire [11:0] buck3_on_mv,
  input wire [11:0] buck3_sleep_mv,
  input wire [6:0] buck2_sleep_code_clamped
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Ramp opens on step one and only counts upward
  ramp_start_a: assert property ($rose(buck3_ramp_busy) |-> buck3_ramp_step == 2'h1)
    else $error("ramp did not open on step one");
  ramp_step_a: assert property ($changed(buck3_ramp_step) && buck3_ramp_busy
    |-> buck3_ramp_step == $past(buck3_ramp_step) + 2'h1) else $error("ramp step skipped");
  ramp_end_a: assert property ($fell(buck3_ramp_busy) |-> buck3_ramp_step == 2'h3)
    else $error("ramp ended early");
  // Limit moves only after a write with the key open
  limit_key_a: assert property ($changed(buck3_hyst_limit_ma) |-> $past(key_unlocked))
    else $error("limit changed while locked");
  limit_map_a: assert property (buck3_hyst_limit_ma inside {10'h064, 10'h0C8, 10'h190, 10'h320})
    else $error("limit outside its four values");
  // Buck3 voltages stay in range, the sleep voltage also on the grid
  on_range_a: assert property (buck3_on_mv >= 12'h352 && buck3_on_mv <= 12'hD48)
    else $error("on voltage out of range");
  sleep_grid_a: assert property (buck3_sleep_mv >= 12'h352 && buck3_sleep_mv <= 12'hD48
    && (buck3_sleep_mv - 12'h352) % 12'h019 == 12'h000) else $error("sleep voltage off grid");
  b2_clamp_a: assert property (buck2_sleep_code_clamped inside {[7'h08:7'h68]})
    else $error("buck2 code not clamped");
  // Read data holds between read address phases
  rdata_hold_a: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata))
    else $error("read data moved");
endmodule // bcr_regs_sva

// >>> test/bcr_regs_tb.sv
// Self-checking bench for the buck register bank.
// Assumes bcr_regs, its defines and the checker are compiled first.
`timescale 1ns/10ps
`include "bcr_defs.vh"
module bcr_regs_tb;
  reg core_clk = 1'b0;
  reg rst_n = 1'b0;
  reg hsel = 1'b0;
  reg [31:0] haddr = 32'h0;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 1'b0;
  reg [31:0] hwdata = 32'h0;
  reg key_unlocked = 1'b0;
  reg otp_load = 1'b0;
  reg [4:0] otp_on_code = 5'h00;
  reg pin_one = 1'b0;
  reg pin_two = 1'b0;
  reg buck3_start = 1'b0;
  wire [31:0] hrdata;
  wire hreadyout;
  wire hresp;
  wire [1:0] cap;
  wire ovp;
  wire [1:0] step;
  wire busy;
  wire [9:0] lim;
  wire [11:0] on_mv, slp_mv;
  wire [6:0] b2_on, b2_slp, b2_scl;
  wire active;
  reg [31:0] rdat;
  reg [15:0] idx [0:5], rstv [0:5], msk [0:5], cv [0:7];
  int num_errors = 0, compares = 0, dur [0:3], i, j, n, e;
  // Shortened ramp steps
  bcr_regs #(.STEP1_CYC(32'h4), .STEP2_CYC(32'h8), .STEP3_CYC(32'h10)) i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .key_unlocked(key_unlocked), .otp_load(otp_load),
    .otp_on_code(otp_on_code), .hw_scaling_input_one(pin_one),
    .hw_scaling_input_two(pin_two), .buck3_start(buck3_start), .buck3_ramp_step(step),
    .buck3_ramp_busy(busy), .buck3_hyst_limit_ma(lim), .buck3_on_mv(on_mv),
    .buck3_sleep_mv(slp_mv), .buck2_on_code_clamped(b2_on),
    .buck2_sleep_code_clamped(b2_slp), .buck2_scaling_code_clamped(b2_scl),
    .buck2_scaling_active(active), .buck3_output_cap_range(cap), .buck3_overvoltage_guard(ovp));
  // 25 MHz clock
  always #20 core_clk = ~core_clk;
  task chk(input [31:0] got, input [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One single AHB-Lite transfer; byte address is index times four
  task bus(input w, input [15:0] ix, input [15:0] wd, output [31:0] rd);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {14'h0000, ix, 2'h0};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0000, wd};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task wr(input [15:0] ix, input [15:0] d);
    bus(1'b1, ix, d, rdat);
  endtask
  task rdc(input [15:0] ix, input [15:0] x);
    bus(1'b0, ix, 16'h0000, rdat);
    chk(rdat, {16'h0000, x});
  endtask
  // Let a write reach the decoded outputs
  task settle;
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  task end_of_test;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    #100000;
    num_errors++;
    end_of_test;
  end
  initial
  begin
    idx = '{`BCR_IDX_B2_SLEEP, `BCR_IDX_B2_SCALE, `BCR_IDX_B3_CTL1, `BCR_IDX_B3_CTL2,
      `BCR_IDX_B3_ON, `BCR_IDX_B3_SLEEP};
    rstv = '{16'h0000, 16'h0000, `BCR_RST_B3_CTL1, `BCR_RST_B3_CTL2, 16'h0000, 16'h0000};
    msk = '{`BCR_MASK_B2_SLEEP, `BCR_MASK_B2_SCALE, (`BCR_MASK_B3_CTL1 & 16'hFFF3) | 16'h0004,
      `BCR_MASK_B3_CTL2, `BCR_MASK_B3_ON, `BCR_MASK_B3_SLEEP};
    cv = '{16'h00, 16'h08, 16'h09, 16'h65, 16'h66, 16'h67, 16'h68, 16'h7F};
    dur = '{0, 4, 8, 16};
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    chk(lim, 200);
    chk(on_mv, 850);
    chk({hresp, ovp, cap}, 4'h0);
    // Reset values, then all ones with the key locked
    for (i = 0; i < 6; i++)
    begin
      rdc(idx[i], rstv[i]);
      wr(idx[i], 16'hFFFF);
      rdc(idx[i], msk[i]);
    end
    chk({hresp, ovp, cap}, 4'h7);
    wr(16'h4064, 16'hFFFF);
    rdc(16'h4064, 16'h0000);
    // Every limit code with the key open, then a locked write
    @(posedge core_clk);
    key_unlocked <= 1'b1;
    for (i = 0; i < 4; i++)
    begin
      wr(`BCR_IDX_B3_CTL1, i << 2);
      settle;
      chk(lim, 100 << i);
    end
    @(posedge core_clk);
    key_unlocked <= 1'b0;
    wr(`BCR_IDX_B3_CTL1, 16'h0000);
    settle;
    chk(lim, 800);
    rdc(`BCR_IDX_B3_CTL1, 16'h000C);
    // Voltage codes at both ends of both ranges
    for (i = 0; i < 8; i++)
    begin
      for (j = 2; j < 6; j++)
        if (j != 2 && j != 3) wr(idx[j], cv[i]);
      wr(idx[0], cv[i]);
      wr(idx[1], cv[i]);
      settle;
      e = cv[i] >= 16'h66 ? 3400 : 850 + 25 * cv[i];
      chk(on_mv, e);
      chk(slp_mv, e);
      e = cv[i] < 16'h08 ? 8 : (cv[i] > 16'h68 ? 16'h68 : cv[i]);
      chk(b2_slp, e);
      chk(b2_on, e);
      chk(b2_scl, e);
    end
    // Scaling source against both pins
    for (j = 0; j < 2; j++)
    begin
      @(posedge core_clk);
      pin_one <= (j == 0);
      pin_two <= (j == 1);
      for (i = 0; i < 4; i++)
      begin
        wr(`BCR_IDX_B2_SCALE, i << 11);
        settle;
        chk(active, (i == 1) || (i == 2 && j == 0) || (i == 3 && j == 1));
      end
    end
    // OTP load replaces only the upper five bits
    wr(`BCR_IDX_B3_ON, 16'h007F);
    @(posedge core_clk);
    otp_on_code <= 5'h01;
    otp_load <= 1'b1;
    @(posedge core_clk);
    otp_load <= 1'b0;
    rdc(`BCR_IDX_B3_ON, 16'h0007);
    chk(on_mv, 850 + 25 * 7);
    // Ramp for every step code
    for (i = 0; i < 4; i++)
    begin
      wr(`BCR_IDX_B3_CTL1, i << 4);
      @(posedge core_clk);
      buck3_start <= 1'b1;
      @(posedge core_clk);
      #1;
      n = 0;
      while (busy === 1'b1 && n < 200)
      begin
        n++;
        @(posedge core_clk);
        #1;
      end
      chk(n, 3 * dur[i]);
      chk(step, 2'h3);
      rdc(`BCR_IDX_STATUS, 16'h0007);
      @(posedge core_clk);
      buck3_start <= 1'b0;
    end
    end_of_test;
  end
endmodule // bcr_regs_tb
bind bcr_regs bcr_regs_sva i_sva (.core_clk, .rst_n, .hsel, .htrans, .hwrite, .hready,
  .hrdata, .key_unlocked, .buck3_ramp_step, .buck3_ramp_busy, .buck3_hyst_limit_ma,
  .buck3_on_mv, .buck3_sleep_mv, .buck2_sleep_code_clamped);
